// >>> rtl/capture_trigger_sync_control.sv
// Implementation choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
module capture_trigger_sync_control (
  // ahb-lite clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // sync and trigger sources from other modules, same clock
  input wire logic [capture_pkg::source_count-1:0] sync_sources,
  // capture pin
  input wire logic capture_pin,
  // interrupt
  output logic irq
);
  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [31:0] a, input logic [7:0] off);
    hit = (a[31:capture_pkg::addr_msb+1] == '0) &&
          (a[capture_pkg::addr_msb:capture_pkg::addr_lsb] ==
           off[capture_pkg::addr_msb:capture_pkg::addr_lsb]);
  endfunction : hit

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic cascade_select;
  logic trigger_mode_select;
  logic timer_trigger_status;
  logic [4:0] sync_source_select;
  logic [capture_pkg::irq_width-1:0] irq_status;
  logic [capture_pkg::irq_width-1:0] irq_mask;
  logic [capture_pkg::timer_width-1:0] capture_value;
  logic [capture_pkg::timer_width-1:0] capture_timer;
  logic source_prev;
  logic pin_prev;
  logic pin_level;
  logic wr_pending;
  logic rd_pending;
  logic [31:0] addr_held;
  logic next_status;

  // ----------------------------------------------------------------
  // bus phases
  // ----------------------------------------------------------------
  wire addr_phase = hsel && hready && (htrans == capture_pkg::htrans_nonseq);
  wire wr_ctrl = wr_pending && hit(addr_held, capture_pkg::ctrl_offset);
  wire wr_istat = wr_pending && hit(addr_held, capture_pkg::irq_status_offset);
  wire wr_imask = wr_pending && hit(addr_held, capture_pkg::irq_mask_offset);

  // ----------------------------------------------------------------
  // source selection and trigger
  // ----------------------------------------------------------------
  // select zero means no source; a change of select may look like an edge
  wire source_now = sync_sources[sync_source_select];
  wire source_fire = source_now && !source_prev &&
                     (sync_source_select != capture_pkg::sel_none);
  wire pin_rise = pin_level && !pin_prev;

  // set by the source wins over a software clear in the same cycle
  assign next_status = source_fire ? 1'b1 :
                       wr_ctrl ? hwdata[capture_pkg::trig_status_bit] :
                       timer_trigger_status;

  // trigger mode runs only while triggered; sync mode restarts on the source
  wire timer_run = trigger_mode_select ? timer_trigger_status : 1'b1;
  wire timer_clear = trigger_mode_select ? !timer_trigger_status
                                         : source_fire;

  wire [capture_pkg::irq_width-1:0] irq_events = {pin_rise, source_fire};
  wire [capture_pkg::irq_width-1:0] next_irq_status =
    irq_events | (irq_status & ~(wr_istat ? hwdata[1:0] : 2'h0));

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  wire [31:0] ctrl_word = {16'h0000, 7'h00, cascade_select,
                           trigger_mode_select, timer_trigger_status, 1'b0,
                           sync_source_select};
  wire [31:0] read_word =
    hit(addr_held, capture_pkg::ctrl_offset) ? ctrl_word :
    hit(addr_held, capture_pkg::irq_status_offset) ? {30'h0, irq_status} :
    hit(addr_held, capture_pkg::irq_mask_offset) ? {30'h0, irq_mask} :
    hit(addr_held, capture_pkg::timer_offset) ? capture_timer :
    hit(addr_held, capture_pkg::capture_offset) ? capture_value : 32'h0;

  // ----------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------
  pin_filter u_pin (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(capture_pin),
    .level(pin_level)
  );

  capture_counter u_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(timer_run),
    .clear(timer_clear),
    .wide(cascade_select),
    .count(capture_timer)
  );

  // ----------------------------------------------------------------
  // bus slave: writes take no wait; reads take one so that a write
  // still in its data phase lands before the read samples
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pending <= 1'b0;
      rd_pending <= 1'b0;
      addr_held <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
      hresp <= capture_pkg::hresp_okay;
    end else begin
      wr_pending <= addr_phase && hwrite;
      rd_pending <= addr_phase && !hwrite;
      hreadyout <= !(addr_phase && !hwrite);
      if (addr_phase) begin
        addr_held <= haddr;
      end
      if (rd_pending) begin
        hrdata <= read_word;
      end
    end
  end

  // ----------------------------------------------------------------
  // control and interrupt registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cascade_select <= 1'b0;
      trigger_mode_select <= 1'b0;
      timer_trigger_status <= 1'b0;
      sync_source_select <= capture_pkg::sel_reset;
      irq_mask <= capture_pkg::irq_mask_reset;
    end else begin
      timer_trigger_status <= next_status;
      if (wr_ctrl) begin
        cascade_select <= hwdata[capture_pkg::cascade_bit];
        trigger_mode_select <= hwdata[capture_pkg::trig_mode_bit];
        sync_source_select <= hwdata[4:0];
      end
      if (wr_imask) begin
        irq_mask <= hwdata[1:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= '0;
      irq <= 1'b0;
      source_prev <= 1'b0;
      pin_prev <= 1'b0;
      capture_value <= '0;
    end else begin
      irq_status <= next_irq_status;
      irq <= |(irq_status & irq_mask);
      source_prev <= source_now;
      pin_prev <= pin_level;
      if (pin_rise) begin
        capture_value <= capture_timer;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  hold_clear_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    trigger_mode_select && !timer_trigger_status |=> capture_timer == 0)
    else $error("timer not held clear while untriggered");

  trigger_set_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    source_fire |=> timer_trigger_status)
    else $error("trigger did not set status");

  narrow_upper_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !cascade_select |=> capture_timer[31:16] == 16'h0000)
    else $error("upper half counts without cascade");

  wide_carry_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    cascade_select && timer_run && !timer_clear &&
    capture_timer[15:0] == 16'hffff
    |=> capture_timer[31:16] == $past(capture_timer[31:16]) + 16'h0001)
    else $error("cascade carry lost");

  run_count_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    trigger_mode_select && timer_trigger_status && !cascade_select &&
    capture_timer[15:0] != 16'hffff
    |=> capture_timer == $past(capture_timer) + 32'h0000_0001)
    else $error("triggered timer not running");

  sync_restart_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !trigger_mode_select && source_fire |=> capture_timer == 0)
    else $error("sync did not restart timer");

  status_write_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_ctrl && !source_fire
    |=> timer_trigger_status == $past(hwdata[capture_pkg::trig_status_bit]))
    else $error("status write not taken");

  reserved_zero_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_pending && hit(addr_held, capture_pkg::ctrl_offset)
    |=> hrdata[31:9] == 23'h0 && hrdata[5] == 1'b0)
    else $error("reserved bits read nonzero");

  stop_on_clear_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    trigger_mode_select && wr_ctrl && !source_fire &&
    hwdata[capture_pkg::trig_mode_bit] &&
    !hwdata[capture_pkg::trig_status_bit]
    |=> ##1 capture_timer == 0)
    else $error("timer not stopped after status clear");

  irq_level_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ##1 irq == $past(|(irq_status & irq_mask)))
    else $error("interrupt level wrong");

  read_wait_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    addr_phase && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");

  write_ready_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    addr_phase && hwrite |=> hreadyout)
    else $error("write inserted a wait state");

  resp_okay_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    hresp == capture_pkg::hresp_okay)
    else $error("response not okay");

  event_sticky_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    source_fire |=> irq_status[capture_pkg::irq_trigger_bit])
    else $error("trigger event not recorded");

  status_idle_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !timer_trigger_status && !wr_ctrl && !sync_sources[sync_source_select]
    |=> !timer_trigger_status)
    else $error("status set without selected source");

  status_keep_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    timer_trigger_status && !wr_ctrl |=> timer_trigger_status)
    else $error("trigger status dropped without software");

  ctrl_write_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_ctrl |=> cascade_select == $past(hwdata[capture_pkg::cascade_bit]) &&
    sync_source_select == $past(hwdata[4:0]))
    else $error("control write not taken");

  mode_write_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_ctrl
    |=> trigger_mode_select == $past(hwdata[capture_pkg::trig_mode_bit]))
    else $error("mode write not taken");

  capture_take_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    pin_rise |=> capture_value == $past(capture_timer))
    else $error("capture value not taken");

  event_clear_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_istat && hwdata[capture_pkg::irq_trigger_bit] && !source_fire
    |=> !irq_status[capture_pkg::irq_trigger_bit])
    else $error("trigger event not cleared");
endmodule : capture_trigger_sync_control

// >>> rtl/capture_pkg.sv
package capture_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ctrl_offset = 8'h00;
  localparam logic [7:0] irq_status_offset = 8'h04;
  localparam logic [7:0] irq_mask_offset = 8'h08;
  localparam logic [7:0] timer_offset = 8'h0c;
  localparam logic [7:0] capture_offset = 8'h10;
  localparam int addr_lsb = 2;
  localparam int addr_msb = 7;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int cascade_bit = 8;
  localparam int trig_mode_bit = 7;
  localparam int trig_status_bit = 6;
  localparam int sel_lsb = 0;
  localparam int sel_width = 5;
  localparam int ctrl_width = 16;
  localparam logic [4:0] sel_reset = 5'h0d;
  localparam logic [4:0] sel_none = 5'h00;

  // ----------------------------------------------------------------
  // interrupt status / mask fields
  // ----------------------------------------------------------------
  localparam int irq_width = 2;
  localparam int irq_trigger_bit = 0;
  localparam int irq_capture_bit = 1;
  localparam logic [1:0] irq_mask_reset = 2'h0;

  // ----------------------------------------------------------------
  // timer
  // ----------------------------------------------------------------
  localparam int timer_width = 32;
  localparam int half_width = 16;
  localparam int source_count = 32;

  // ----------------------------------------------------------------
  // ahb encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] htrans_nonseq = 2'h2;
  localparam logic hresp_okay = 1'b0;
endpackage : capture_pkg

// >>> rtl/pin_filter.sv
`timescale 1ns/1ps
module pin_filter (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // pin and filtered level
  input wire logic pin,
  output logic level
);
  logic stage1;
  logic stage2;
  logic stage3;

  // stage1 feeds stage2 only; a change counts once stage2 and stage3 agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      level <= 1'b0;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3) begin
        level <= stage3;
      end
    end
  end
endmodule : pin_filter

// >>> rtl/capture_counter.sv
`timescale 1ns/1ps
module capture_counter (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic run,
  input wire logic clear,
  input wire logic wide,
  // count
  output logic [capture_pkg::timer_width-1:0] count
);
  localparam int hw = capture_pkg::half_width;
  localparam logic [hw-1:0] zero_half = 16'h0000;

  logic [capture_pkg::timer_width-1:0] next_count;
  wire [capture_pkg::timer_width-1:0] inc_wide = count + 32'h0000_0001;
  wire [hw-1:0] inc_low = count[hw-1:0] + 16'h0001;

  // in narrow mode the upper half is held at zero and the low half wraps
  assign next_count = clear ? '0 :
                      !run ? count :
                      wide ? inc_wide : {zero_half, inc_low};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end
endmodule : capture_counter

// >>> test/source_model.sv
`timescale 1ns/1ps
module source_model (
  // clock
  input wire logic hclk,
  // request from the bench
  input wire logic fire,
  input wire logic [4:0] fire_sel,
  // sync and trigger lines of the other modules
  output logic [capture_pkg::source_count-1:0] sync_sources
);
  // ----------------------------------------------------------------
  // one-cycle pulse on the chosen line
  // ----------------------------------------------------------------
  wire [capture_pkg::source_count-1:0] one_hot =
    {{(capture_pkg::source_count-1){1'b0}}, 1'b1} << fire_sel;

  // a request held for one cycle gives a one-cycle pulse and a clean rising edge,
  // but requests on consecutive cycles merge into one pulse with one edge
  always @(posedge hclk) begin
    sync_sources <= fire ? one_hot : '0;
  end
endmodule : source_model

// >>> test/tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  error_cnt++; $display("ERROR %s expected %h seen %h", n, e, g); end end
module tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = '0;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic irq;
  logic [31:0] hrdata;
  logic [31:0] t1;
  logic [31:0] t2;
  logic [31:0] sync_sources;
  logic capture_pin = 1'b0;
  logic fire = 1'b0;
  logic [4:0] fire_sel = '0;
  int error_cnt = 0;
  int check_count = 0;
  int cycles = 0;

  assign hready = hreadyout;
  always #25 hclk = ~hclk;

  capture_trigger_sync_control i_capture_trigger_sync_control (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .sync_sources(sync_sources),
    .capture_pin(capture_pin), .irq(irq));

  source_model i_source_model (.hclk(hclk), .fire(fire),
    .fire_sel(fire_sel), .sync_sources(sync_sources));

  // ----------------------------------------------------------------
  // bus tasks, entered just after a rising edge
  // ----------------------------------------------------------------
  task automatic ahb(input logic wr_en, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr_en;
    htrans <= capture_pkg::htrans_nonseq;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask : bus_write

  task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
    ahb(1'b0, a, 32'h0, d);
  endtask : bus_read

  task automatic pulse(input logic [4:0] s);
    fire_sel <= s;
    fire <= 1'b1;
    @(posedge hclk);
    fire <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask : pulse

  task automatic conclude;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  // the wide-count test alone needs about 66000 cycles
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      error_cnt++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    `CHK("irq reset", 1'b0, irq)
    `CHK("hresp", 1'b0, hresp)
    bus_read(capture_pkg::ctrl_offset, t1);
    `CHK("ctrl reset", 32'h0000000d, t1)
    bus_write(capture_pkg::ctrl_offset, 32'hffffffff);
    bus_read(capture_pkg::ctrl_offset, t1);
    `CHK("ctrl reserved", 32'h000001df, t1)
    // trigger mode on source 3, which is never this module itself
    bus_write(capture_pkg::ctrl_offset, 32'h00000083);
    bus_read(capture_pkg::timer_offset, t1);
    `CHK("timer held", 32'h0, t1)
    pulse(5'h04);
    bus_read(capture_pkg::ctrl_offset, t1);
    `CHK("other source", 32'h00000083, t1)
    bus_read(capture_pkg::timer_offset, t1);
    `CHK("timer still held", 32'h0, t1)
    pulse(5'h03);
    bus_read(capture_pkg::ctrl_offset, t1);
    `CHK("status set", 32'h000000c3, t1)
    bus_read(capture_pkg::timer_offset, t1);
    bus_read(capture_pkg::timer_offset, t2);
    `CHK("timer step", 32'h3, t2 - t1)
    bus_read(capture_pkg::irq_status_offset, t1);
    `CHK("irq status", 32'h1, t1)
    `CHK("irq masked", 1'b0, irq)
    bus_write(capture_pkg::irq_mask_offset, 32'h1);
    repeat (2) @(posedge hclk);
    `CHK("irq on", 1'b1, irq)
    bus_write(capture_pkg::irq_status_offset, 32'h1);
    repeat (2) @(posedge hclk);
    `CHK("irq cleared", 1'b0, irq)
    bus_write(capture_pkg::ctrl_offset, 32'h00000083);
    bus_read(capture_pkg::ctrl_offset, t1);
    `CHK("sw clear", 32'h00000083, t1)
    bus_read(capture_pkg::timer_offset, t1);
    `CHK("timer stopped", 32'h0, t1)
    bus_write(capture_pkg::ctrl_offset, 32'h000000c3);
    bus_read(capture_pkg::timer_offset, t1);
    `CHK("sw set runs", 1'b1, t1 != 32'h0)
    bus_write(capture_pkg::ctrl_offset, 32'h00000003);
    repeat (100) @(posedge hclk);
    bus_read(capture_pkg::timer_offset, t1);
    `CHK("free run", 1'b1, t1 > 32'd100)
    pulse(5'h03);
    bus_read(capture_pkg::timer_offset, t2);
    `CHK("sync restart", 1'b1, t2 < 32'd12)
    // the pair partner is not modelled; this module is set first
    bus_write(capture_pkg::ctrl_offset, 32'h00000103);
    repeat (66000) @(posedge hclk);
    bus_read(capture_pkg::timer_offset, t1);
    `CHK("wide count", 1'b1, t1 > 32'h0000ffff)
    bus_write(capture_pkg::ctrl_offset, 32'h00000003);
    bus_read(capture_pkg::timer_offset, t1);
    `CHK("narrow upper", 16'h0, t1[31:16])
    bus_write(8'h20, 32'hffffffff);
    bus_read(8'h20, t1);
    `CHK("unmapped", 32'h0, t1)
    capture_pin <= 1'b1;
    repeat (6) @(posedge hclk);
    bus_read(capture_pkg::irq_status_offset, t1);
    `CHK("capture event", 1'b1, t1[1])
    bus_read(capture_pkg::capture_offset, t1);
    `CHK("capture value", 1'b1, t1 != 32'h0)
    bus_read(capture_pkg::timer_offset, t2);
    `CHK("capture order", 1'b1, t2 > t1)
    `CHK("hresp end", 1'b0, hresp)
    conclude();
  end
endmodule : tb_top
